// ---- shared/vmc_cfg.svh ----
`ifndef VMC_CFG_SVH
`define VMC_CFG_SVH
// What this block does
// (RL1) indivisible field 001/010/011/x00 pick request, stretch and hold of the bus
// (RL2) codes 101/110/111 choose behaviour from byte or non-byte first transfer
// (RL3) as slave to single-address indivisible cycle, hold local request while AS asserted
// (RL4) software without indivisible support uses capture-hold release mode around its cycles
// (RL5) request-and-hold mode: local cycle completes only after mastership is obtained
// (RL6) deadlock when requesting for master-want or interrupt-ack while slave select valid
// (RL7) deadlock signals: deadlock alone, with bus error and halt, or error only; the error-only mode drives the error only during an indivisible cycle
// (RL8) deadlock output stays asserted until the causing slave access completes
// (RL9) after deadlock keep requesting; reasserted master-want on held bus runs normally
// (RL10) grant without master-want: busy 90 ns when release-when-done, hold on release-on-request
// (RL11) slave select while master: local bus error, BERR and self-access status bit
// (RL12) size code 00 long, 01 byte, 10 word, 11 three-byte drives LWORD, A01, strobes
// (RL13) narrow port: D16 transfer, no LWORD, swap and isolation enables by size
// (RL14) D16 master cycles acknowledge on the upper port acknowledge line only
// (RL15) 16-bit local processor must assert narrow port on every master transfer
// (RL16) fair mode: do not request until the request level is deasserted
// (RL17) fair timeout expiry abandons fairness and requests immediately
// (RL18) arbitration field 0 no fairness, F no timeout, else 2 us per count
// (RL19) never generate address-only cycles as master; accept them as slave
// (RL20) modifier from size select and function code; select 00 uses source register
// (RL21) source top bit clear drives bits 5:0; set combines bits 5:3 with function code
// (RL22) select 01 gives A32 codes, 11 gives A24 codes, with block variants
`define VMC_SIZ_LONG 2'h0
`define VMC_SIZ_BYTE 2'h1
`define VMC_SIZ_WORD 2'h2
`define VMC_SIZ_TRI 2'h3
`define VMC_ICR_HOLD_ONLY 3'h1
`define VMC_ICR_STR_ONLY 3'h2
`define VMC_ICR_ALL 3'h3
`define VMC_ICR_NB_REQ 3'h5
`define VMC_ICR_B_STR 3'h6
`define VMC_ICR_MIX 3'h7
`define VMC_DL_ONLY 2'h0
`define VMC_DL_ERR_HALT 2'h1
`define VMC_DL_ERR_RMC 2'h2
`define VMC_ARB_OFF 4'h0
`define VMC_ARB_NOTO 4'hF
`define VMC_AS_USER 2'h0
`define VMC_AS_A32 2'h1
`define VMC_AS_A16 2'h2
`define VMC_AS_A24 2'h3
`define VMC_AM_A32 3'h1
`define VMC_AM_A24 3'h7
`define VMC_AM_A16 3'h5
`define VMC_MODIFIER_SOURCE_REGISTER_FC_BIT 7
`define VMC_CLK_NS 10
`define VMC_BBSY_NS 90
`define VMC_BBSY_CYC ((`VMC_BBSY_NS + `VMC_CLK_NS - 1) / `VMC_CLK_NS)
`define VMC_STEP_NS 2000
`define VMC_STEP_CYC (`VMC_STEP_NS / `VMC_CLK_NS)
`define VMC_REL_ROR 2'h0
`define VMC_REL_RWD 2'h1
`define VMC_REL_CAPTURE_HOLD_RELEASE 2'h3
`endif

// ---- shared/vmc_pkg.sv ----
package vmc_pkg;
	typedef enum logic [1:0] {VMC_DL_NONE_T, VMC_DL_ACTIVE, VMC_DL_WAIT} vmc_dl_t;
	typedef enum logic [1:0] {VMC_IDLE, VMC_REQ, VMC_MASTER, VMC_PARK} vmc_bus_t;
	typedef logic [5:0] vmc_am_t;
endpackage : vmc_pkg

// ---- verilog/vmc_sync.sv ----
`timescale 1ns/1ns
// two-flop synchroniser, one per asynchronous pin
module vmc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
		end
	end
	assign q = s2_q;
endmodule : vmc_sync

// ---- verilog/vmc_master_ctl.sv ----
`timescale 1ns/1ns
`include "vmc_cfg.svh"
module vmc_master_ctl #(
	parameter int STEP_CYC = `VMC_STEP_CYC
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// configuration
	input wire logic [2:0] INDIVISIBLE_CONTROL_FIELD,
	input wire logic [1:0] DEADLOCK_MODE,
	input wire logic [1:0] RELEASE_CONTROL_FIELD,
	input wire logic [3:0] ARBITRATION_REQUEST_FIELD,
	input wire logic [7:0] MODIFIER_SOURCE_REGISTER,
	// local master side, active low request, indivisible and narrow port pins
	input wire logic MASTER_WANT_BUS_N,
	input wire logic INTERRUPT_ACK_REQUEST_N,
	input wire logic INDIVISIBLE_CYCLE_IN_N,
	input wire logic NARROW_PORT_N,
	input wire logic [1:0] TRANSFER_SIZE_CODE,
	input wire logic [1:0] LOCAL_ADDR_LOW,
	input wire logic LOCAL_WRITE,
	input wire logic BLOCK_XFER,
	input wire logic [1:0] ADDRESS_SIZE_SELECT,
	input wire logic [1:0] FUNCTION_CODE_IN,
	// vmebus side
	input wire logic BGIN_N,
	input wire logic BR_LEVEL_N,
	input wire logic AS_IN_N,
	input wire logic DTACK_IN_N,
	input wire logic RELEASE_REQ_N,
	input wire logic SLAVE_SELECT_N,
	input wire logic SLAVE_DONE,
	input wire logic SLAVE_INDIVISIBLE,
	// outputs
	output logic BR_N,
	output logic BBSY_N,
	output logic AS_STRETCH,
	output logic [5:0] AM_OUT,
	output logic LWORD_N,
	output logic A01,
	output logic [1:0] DS_N,
	output logic PORT_ACK_UPPER_N,
	output logic PORT_ACK_LOWER_N,
	output logic SWAP_DATA_ENABLE_N,
	output logic ISOLATION_BUFFER_ENABLE_N,
	output logic DEADLOCK_OUT_N,
	output logic LOCAL_BUS_ERROR_OUT_N,
	output logic HALT_N,
	output logic BERR_N,
	output logic LOCAL_BUS_REQUEST_N,
	output logic SELF_ACCESS_STATUS
);
	import vmc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [9:0] raw;
	logic [9:0] syn;
	// pins are inverted ahead of the flops so their reset value of zero reads as idle
	assign raw = ~{MASTER_WANT_BUS_N, INTERRUPT_ACK_REQUEST_N, INDIVISIBLE_CYCLE_IN_N,
		BGIN_N, BR_LEVEL_N, AS_IN_N, DTACK_IN_N, RELEASE_REQ_N, SLAVE_SELECT_N,
		NARROW_PORT_N};
	vmc_sync #(.W(10)) u_sync (
		.clk(CLOCK),
		.rst_n(RST_N),
		.d(raw),
		.q(syn)
	);
	logic mwb;
	logic iack;
	logic rmc;
	logic bg;
	logic lvl_busy;
	logic as_v;
	logic dtack;
	logic rel_req;
	logic ssel;
	logic narrow;
	assign mwb = syn[9];
	assign iack = syn[8];
	assign rmc = syn[7];
	assign bg = syn[6];
	assign lvl_busy = syn[5];
	assign as_v = syn[4];
	assign dtack = syn[3];
	assign rel_req = syn[2];
	assign ssel = syn[1];
	assign narrow = syn[0];

	////////////////////////////////////////////////////////////////////////////////
	// indivisible mode decode
	logic is_byte;
	logic rmc_req;
	logic rmc_str;
	logic rmc_hold;
	assign is_byte = (TRANSFER_SIZE_CODE == `VMC_SIZ_BYTE);
	always_comb begin
		rmc_req = 1'b0;
		rmc_str = 1'b0;
		rmc_hold = 1'b0;
		case (INDIVISIBLE_CONTROL_FIELD)
			`VMC_ICR_HOLD_ONLY: begin
				rmc_req = 1'b1; // [RL1]
				rmc_hold = 1'b1;
			end
			`VMC_ICR_STR_ONLY: begin
				rmc_str = 1'b1; // [RL1]
				rmc_hold = 1'b1;
			end
			`VMC_ICR_ALL: begin
				rmc_req = 1'b1; // [RL1]
				rmc_str = 1'b1;
				rmc_hold = 1'b1;
			end
			`VMC_ICR_NB_REQ: begin
				rmc_req = !is_byte; // [RL2]
				rmc_hold = !is_byte;
			end
			`VMC_ICR_B_STR: begin
				rmc_str = is_byte; // [RL2]
				rmc_hold = is_byte;
			end
			`VMC_ICR_MIX: begin
				rmc_str = is_byte; // [RL2]
				rmc_req = !is_byte;
				rmc_hold = 1'b1;
			end
			default: begin
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// arbitration, fairness and bus ownership
	vmc_bus_t bus_q;
	vmc_bus_t bus_d;
	logic [3:0] steps_q;
	logic [3:0] steps_d;
	logic [$clog2(STEP_CYC+1)-1:0] tick_q;
	logic [$clog2(STEP_CYC+1)-1:0] tick_d;
	logic unfair_q;
	logic unfair_d;
	logic [3:0] bbsy_cnt_q;
	logic [3:0] bbsy_cnt_d;
	logic br_q;
	logic br_d;
	logic bbsy_q;
	logic bbsy_d;
	logic first_q;
	logic first_d;
	logic want;
	logic held;
	logic fair_on;
	logic to_on;
	logic dl_block;
	assign held = (bus_q == VMC_MASTER) || (bus_q == VMC_PARK);
	assign fair_on = (ARBITRATION_REQUEST_FIELD != `VMC_ARB_OFF);
	assign to_on = fair_on && (ARBITRATION_REQUEST_FIELD != `VMC_ARB_NOTO);
	assign want = mwb || iack || (rmc && rmc_req) ||
		(RELEASE_CONTROL_FIELD == `VMC_REL_CAPTURE_HOLD_RELEASE);
	always_comb begin
		bus_d = bus_q;
		steps_d = steps_q;
		tick_d = tick_q;
		unfair_d = unfair_q;
		bbsy_cnt_d = bbsy_cnt_q;
		br_d = 1'b0;
		bbsy_d = bbsy_q;
		first_d = first_q;
		case (bus_q)
			VMC_IDLE: begin
				steps_d = 4'h0;
				tick_d = '0;
				unfair_d = 1'b0;
				if (want || dl_block) begin
					bus_d = VMC_REQ;
				end
			end
			VMC_REQ: begin
				// timeout step counter, at most one step late
				if (to_on && !unfair_q) begin
					if (tick_q == ($clog2(STEP_CYC+1))'(STEP_CYC - 1)) begin
						tick_d = '0;
						steps_d = steps_q + 4'h1;
						if (steps_q + 4'h1 >= ARBITRATION_REQUEST_FIELD) begin
							unfair_d = 1'b1; // [RL17]
						end
					end else begin
						tick_d = tick_q + 1'b1;
					end
				end
				// fair mode waits for the level to clear before asserting
				br_d = br_q || !fair_on || unfair_q || !lvl_busy; // [RL16]
				if (bg && br_q) begin
					bus_d = VMC_MASTER;
					bbsy_d = 1'b1;
					br_d = 1'b0;
					first_d = 1'b1;
					bbsy_cnt_d = 4'h0;
				end
			end
			VMC_MASTER: begin
				first_d = 1'b0;
				if (bbsy_cnt_q != 4'hF) begin
					bbsy_cnt_d = bbsy_cnt_q + 4'h1;
				end
				// grant after deadlock with no renewed want: park on the bus
				if (!want && !(rmc && rmc_hold)) begin
					bus_d = VMC_PARK; // [RL9] [RL10]
				end
			end
			VMC_PARK: begin
				if (bbsy_cnt_q != 4'hF) begin
					bbsy_cnt_d = bbsy_cnt_q + 4'h1;
				end
				if (want) begin
					bus_d = VMC_MASTER; // [RL9]
				end else if (RELEASE_CONTROL_FIELD == `VMC_REL_ROR) begin
					if (rel_req) begin
						bus_d = VMC_IDLE; // [RL10]
						bbsy_d = 1'b0;
					end
				end else if (bbsy_cnt_q >= 4'(`VMC_BBSY_CYC - 1)) begin
					bus_d = VMC_IDLE; // [RL10]
					bbsy_d = 1'b0;
				end
			end
			default: begin
				bus_d = VMC_IDLE;
			end
		endcase
	end
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			bus_q <= VMC_IDLE;
			steps_q <= 4'h0;
			tick_q <= '0;
			unfair_q <= 1'b0;
			bbsy_cnt_q <= 4'h0;
			br_q <= 1'b0;
			bbsy_q <= 1'b0;
			first_q <= 1'b0;
		end else begin
			bus_q <= bus_d;
			steps_q <= steps_d;
			tick_q <= tick_d;
			unfair_q <= unfair_d;
			bbsy_cnt_q <= bbsy_cnt_d;
			br_q <= br_d;
			bbsy_q <= bbsy_d;
			first_q <= first_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// deadlock and self-access
	vmc_dl_t dl_q;
	vmc_dl_t dl_d;
	logic halt_d;
	logic local_bus_error_out_d;
	logic berr_d;
	logic self_d;
	logic self_q;
	logic lbr_d;
	assign dl_block = (dl_q != VMC_DL_NONE_T);
	always_comb begin
		dl_d = dl_q;
		self_d = self_q;
		case (dl_q)
			VMC_DL_NONE_T: begin
				if ((mwb || iack) && (bus_q == VMC_REQ) && ssel) begin
					dl_d = VMC_DL_ACTIVE; // [RL6]
				end
			end
			VMC_DL_ACTIVE: begin
				if (SLAVE_DONE) begin
					dl_d = VMC_DL_NONE_T; // [RL8]
				end
			end
			default: begin
				dl_d = VMC_DL_NONE_T;
			end
		endcase
		// self-access status sets on every slave select while master, cleared only by reset
		if (ssel && held) begin
			self_d = 1'b1; // [RL11]
		end
		local_bus_error_out_d = 1'b0;
		halt_d = 1'b0;
		if (dl_d == VMC_DL_ACTIVE) begin
			case (DEADLOCK_MODE)
				`VMC_DL_ERR_HALT: begin
					local_bus_error_out_d = 1'b1; // [RL7]
					halt_d = 1'b1;
				end
				`VMC_DL_ERR_RMC: begin
					local_bus_error_out_d = rmc; // [RL7]
				end
				default: begin
				end
			endcase
		end
		berr_d = ssel && held;
		if (berr_d) begin
			local_bus_error_out_d = 1'b1; // [RL11]
		end
		// slave request held through the whole indivisible slave cycle
		lbr_d = (ssel && !held) || (SLAVE_INDIVISIBLE && as_v); // [RL3] [RL19]
	end

	////////////////////////////////////////////////////////////////////////////////
	// transfer sizing, port acknowledge and modifiers
	logic lword_d;
	logic a01_d;
	logic [1:0] ds_d;
	logic ack_up_d;
	logic ack_lo_d;
	logic swap_d;
	logic iso_d;
	logic str_d;
	vmc_am_t am_d;
	logic cycle_ok;
	// request-and-hold cycles cannot finish before mastership
	assign cycle_ok = held && dtack && !(rmc && rmc_req && !held); // [RL5]
	always_comb begin
		a01_d = LOCAL_ADDR_LOW[1];
		lword_d = !narrow && ((TRANSFER_SIZE_CODE == `VMC_SIZ_LONG) ||
			(TRANSFER_SIZE_CODE == `VMC_SIZ_TRI) ||
			(TRANSFER_SIZE_CODE == `VMC_SIZ_WORD && LOCAL_ADDR_LOW == 2'h1)); // [RL12] [RL13]
		if (TRANSFER_SIZE_CODE == `VMC_SIZ_WORD && LOCAL_ADDR_LOW == 2'h1) begin
			a01_d = !narrow;
		end
		case (TRANSFER_SIZE_CODE)
			// bit 1 is the even-byte strobe, bit 0 the odd-byte strobe
			`VMC_SIZ_BYTE: ds_d = LOCAL_ADDR_LOW[0] ? 2'h1 : 2'h2; // [RL12]
			`VMC_SIZ_WORD: ds_d = (LOCAL_ADDR_LOW == 2'h3) ? 2'h1 : 2'h3;
			`VMC_SIZ_TRI: ds_d = LOCAL_ADDR_LOW[0] ? 2'h1 : ((LOCAL_ADDR_LOW == 2'h0) ? 2'h2 : 2'h3);
			default: ds_d = LOCAL_ADDR_LOW[0] ? 2'h1 : 2'h3;
		endcase
		if (narrow) begin
			swap_d = 1'b1; // [RL13]
			iso_d = 1'b0;
		end else if (!LOCAL_WRITE) begin
			iso_d = 1'b1;
			case (TRANSFER_SIZE_CODE)
				`VMC_SIZ_BYTE: swap_d = 1'b1; // [RL13]
				`VMC_SIZ_WORD: swap_d = (LOCAL_ADDR_LOW != 2'h1);
				default: swap_d = LOCAL_ADDR_LOW[1];
			endcase
		end else begin
			case (TRANSFER_SIZE_CODE)
				`VMC_SIZ_BYTE: swap_d = !LOCAL_ADDR_LOW[1]; // [RL13]
				`VMC_SIZ_WORD: swap_d = (LOCAL_ADDR_LOW == 2'h0);
				default: swap_d = 1'b0;
			endcase
			// on writes the swap path and the straight path never open together
			iso_d = !swap_d;
		end
		ack_up_d = cycle_ok;
		ack_lo_d = cycle_ok && !narrow; // [RL14]
		str_d = rmc && rmc_str && held;
		case (ADDRESS_SIZE_SELECT)
			`VMC_AS_A32: am_d = BLOCK_XFER ? {`VMC_AM_A32, FUNCTION_CODE_IN[1], 2'h3} :
				{`VMC_AM_A32, FUNCTION_CODE_IN, ~FUNCTION_CODE_IN[0]}; // [RL22]
			`VMC_AS_A24: am_d = BLOCK_XFER ? {`VMC_AM_A24, FUNCTION_CODE_IN[1], 2'h3} :
				{`VMC_AM_A24, FUNCTION_CODE_IN, ~FUNCTION_CODE_IN[0]}; // [RL22]
			`VMC_AS_A16: am_d = {`VMC_AM_A16, FUNCTION_CODE_IN[1], 2'h1};
			default: am_d = MODIFIER_SOURCE_REGISTER[`VMC_MODIFIER_SOURCE_REGISTER_FC_BIT] ?
				{MODIFIER_SOURCE_REGISTER[5:3], FUNCTION_CODE_IN, ~FUNCTION_CODE_IN[0]} :
				MODIFIER_SOURCE_REGISTER[5:0]; // [RL20] [RL21]
		endcase
	end
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			dl_q <= VMC_DL_NONE_T;
			self_q <= 1'b0;
			DEADLOCK_OUT_N <= 1'b1;
			LOCAL_BUS_ERROR_OUT_N <= 1'b1;
			HALT_N <= 1'b1;
			BERR_N <= 1'b1;
			LOCAL_BUS_REQUEST_N <= 1'b1;
			BR_N <= 1'b1;
			BBSY_N <= 1'b1;
			AS_STRETCH <= 1'b0;
			AM_OUT <= 6'h00;
			LWORD_N <= 1'b1;
			A01 <= 1'b0;
			DS_N <= 2'h3;
			PORT_ACK_UPPER_N <= 1'b1;
			PORT_ACK_LOWER_N <= 1'b1;
			SWAP_DATA_ENABLE_N <= 1'b1;
			ISOLATION_BUFFER_ENABLE_N <= 1'b1;
			SELF_ACCESS_STATUS <= 1'b0;
		end else begin
			dl_q <= dl_d;
			self_q <= self_d;
			DEADLOCK_OUT_N <= !(dl_d == VMC_DL_ACTIVE); // [RL7]
			LOCAL_BUS_ERROR_OUT_N <= !local_bus_error_out_d;
			HALT_N <= !halt_d;
			BERR_N <= !berr_d;
			LOCAL_BUS_REQUEST_N <= !lbr_d;
			BR_N <= !br_d;
			BBSY_N <= !bbsy_d;
			AS_STRETCH <= str_d;
			AM_OUT <= am_d;
			LWORD_N <= !lword_d;
			A01 <= a01_d;
			DS_N <= ~ds_d;
			PORT_ACK_UPPER_N <= !ack_up_d;
			PORT_ACK_LOWER_N <= !ack_lo_d;
			SWAP_DATA_ENABLE_N <= !swap_d;
			ISOLATION_BUFFER_ENABLE_N <= !iso_d;
			SELF_ACCESS_STATUS <= self_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_narrow_nolword: assert property (@(posedge CLOCK) disable iff (!RST_N)
		narrow |=> LWORD_N) else $error("lword asserted on narrow port"); // [RL13]
	a_narrow_ack: assert property (@(posedge CLOCK) disable iff (!RST_N)
		narrow |=> PORT_ACK_LOWER_N) else $error("lower ack on narrow port"); // [RL14]
	a_dl_hold: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(dl_q == VMC_DL_ACTIVE && !SLAVE_DONE) |=> !DEADLOCK_OUT_N) else $error("deadlock dropped"); // [RL8]
	a_dl_detect: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(dl_q == VMC_DL_NONE_T && mwb && bus_q == VMC_REQ && ssel) |=> !DEADLOCK_OUT_N)
		else $error("deadlock missed"); // [RL6]
	a_self_berr: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(ssel && held) |=> (!BERR_N && !LOCAL_BUS_ERROR_OUT_N && SELF_ACCESS_STATUS))
		else $error("self access not flagged"); // [RL11]
	a_fair_wait: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(bus_q == VMC_REQ && fair_on && !unfair_q && lvl_busy && !br_q) |=> BR_N)
		else $error("unfair request"); // [RL16]
	a_ack_master: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(!held) |=> PORT_ACK_UPPER_N) else $error("ack without mastership"); // [RL5]
	a_am_user: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(ADDRESS_SIZE_SELECT == `VMC_AS_USER && !MODIFIER_SOURCE_REGISTER[7])
		|=> AM_OUT == $past(MODIFIER_SOURCE_REGISTER[5:0])) else $error("bad user modifier"); // [RL21]
	a_am_a32: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(ADDRESS_SIZE_SELECT == `VMC_AS_A32 && !BLOCK_XFER && FUNCTION_CODE_IN == 2'h0)
		|=> AM_OUT == 6'h09) else $error("bad a32 modifier"); // [RL22]
	a_rmc_stretch: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(INDIVISIBLE_CONTROL_FIELD == `VMC_ICR_HOLD_ONLY) |=> !AS_STRETCH)
		else $error("stretch in hold-only mode"); // [RL1]
	a_ror_hold: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(bus_q == VMC_PARK && RELEASE_CONTROL_FIELD == `VMC_REL_ROR && !rel_req && !want)
		|=> !BBSY_N) else $error("bus released early"); // [RL10]
	c_deadlock: cover property (@(posedge CLOCK) disable iff (!RST_N) !DEADLOCK_OUT_N);
	c_park: cover property (@(posedge CLOCK) disable iff (!RST_N) bus_q == VMC_PARK);
	c_unfair: cover property (@(posedge CLOCK) disable iff (!RST_N) unfair_q);
	c_self: cover property (@(posedge CLOCK) disable iff (!RST_N) SELF_ACCESS_STATUS);
endmodule : vmc_master_ctl

// ---- test/vmc_far_model.sv ----
`timescale 1ns/1ns
// arbiter and one responding slave standing on the far side of the vmebus
module vmc_far_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// bench controls: grant allowed, answer lag, another master on our level
	input wire logic grant_en,
	input wire logic [3:0] lag,
	input wire logic other_req_n,
	// vmebus lines
	input wire logic br_n,
	input wire logic bbsy_n,
	input wire logic [1:0] ds_n,
	output logic bgin_n,
	output logic br_level_n,
	output logic dtack_n
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic bg_q;
	logic bg_d;
	logic dt_q;
	logic dt_d;

	// the request level is wire-ored with every other master on that level
	assign br_level_n = br_n & other_req_n;
	assign bgin_n = ~bg_q;
	// dtack has a pull-up, so a released line reads high
	assign dtack_n = ~dt_q;

	always_comb begin
		cnt_d = 4'h0;
		bg_d = 1'b0;
		dt_d = 1'b0;
		if (!br_n && bbsy_n && grant_en) begin
			cnt_d = (cnt_q == lag) ? cnt_q : cnt_q + 4'h1;
			bg_d = (cnt_q == lag);
		end else if (!bbsy_n && ds_n != 2'h3) begin
			// the grant count is left at lag, so bg_q clears it on the first busy cycle to restart the answer lag
			cnt_d = bg_q ? 4'h0 : ((cnt_q == lag) ? cnt_q : cnt_q + 4'h1);
			dt_d = !bg_q && (cnt_q == lag);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
			bg_q <= 1'b0;
			dt_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			bg_q <= bg_d;
			dt_q <= dt_d;
		end
	end
endmodule : vmc_far_model

// ---- test/vme_master_cycle_control_tb_top.sv ----
`timescale 1ns/1ns
`include "vmc_cfg.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
`define WAITV(s, v, n) for (k = 0; k < n && s !== v; k++) tick(1);
module vme_master_cycle_control_tb_top;
	localparam int STEP = 4;
	logic CLOCK = 1'b0;
	logic RST_N, MASTER_WANT_BUS_N, INTERRUPT_ACK_REQUEST_N, INDIVISIBLE_CYCLE_IN_N;
	logic NARROW_PORT_N, LOCAL_WRITE, BLOCK_XFER, BGIN_N, BR_LEVEL_N, AS_IN_N, DTACK_IN_N;
	logic RELEASE_REQ_N, SLAVE_SELECT_N, SLAVE_DONE, SLAVE_INDIVISIBLE, BR_N, BBSY_N;
	logic AS_STRETCH, LWORD_N, A01, PORT_ACK_UPPER_N, PORT_ACK_LOWER_N, SWAP_DATA_ENABLE_N;
	logic ISOLATION_BUFFER_ENABLE_N, DEADLOCK_OUT_N, LOCAL_BUS_ERROR_OUT_N, HALT_N, BERR_N;
	logic LOCAL_BUS_REQUEST_N, SELF_ACCESS_STATUS, grant_en, other_req_n;
	logic [2:0] INDIVISIBLE_CONTROL_FIELD;
	logic [1:0] DEADLOCK_MODE, RELEASE_CONTROL_FIELD, TRANSFER_SIZE_CODE, LOCAL_ADDR_LOW;
	logic [1:0] ADDRESS_SIZE_SELECT, FUNCTION_CODE_IN, DS_N;
	logic [3:0] ARBITRATION_REQUEST_FIELD, lag;
	logic [7:0] MODIFIER_SOURCE_REGISTER;
	logic [5:0] AM_OUT;
	int fails = 0;
	int total_checks = 0;
	int k;

	always #5 CLOCK = ~CLOCK;

	vmc_master_ctl #(.STEP_CYC(STEP)) vmc_master_ctl_i (.CLOCK, .RST_N,
		.INDIVISIBLE_CONTROL_FIELD, .DEADLOCK_MODE, .RELEASE_CONTROL_FIELD,
		.ARBITRATION_REQUEST_FIELD, .MODIFIER_SOURCE_REGISTER, .MASTER_WANT_BUS_N,
		.INTERRUPT_ACK_REQUEST_N, .INDIVISIBLE_CYCLE_IN_N, .NARROW_PORT_N, .TRANSFER_SIZE_CODE,
		.LOCAL_ADDR_LOW, .LOCAL_WRITE, .BLOCK_XFER, .ADDRESS_SIZE_SELECT, .FUNCTION_CODE_IN,
		.BGIN_N, .BR_LEVEL_N, .AS_IN_N, .DTACK_IN_N, .RELEASE_REQ_N, .SLAVE_SELECT_N,
		.SLAVE_DONE, .SLAVE_INDIVISIBLE, .BR_N, .BBSY_N, .AS_STRETCH, .AM_OUT, .LWORD_N, .A01,
		.DS_N, .PORT_ACK_UPPER_N, .PORT_ACK_LOWER_N, .SWAP_DATA_ENABLE_N,
		.ISOLATION_BUFFER_ENABLE_N, .DEADLOCK_OUT_N, .LOCAL_BUS_ERROR_OUT_N, .HALT_N, .BERR_N,
		.LOCAL_BUS_REQUEST_N, .SELF_ACCESS_STATUS);

	vmc_far_model vmc_far_model_i (.clk(CLOCK), .rst_n(RST_N), .grant_en(grant_en), .lag(lag),
		.other_req_n(other_req_n), .br_n(BR_N), .bbsy_n(BBSY_N), .ds_n(DS_N),
		.bgin_n(BGIN_N), .br_level_n(BR_LEVEL_N), .dtack_n(DTACK_IN_N));

	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask : tick

	// every scenario starts from a fresh reset so sticky status cannot leak across
	task automatic rst();
		RST_N = 1'b0;
		{INDIVISIBLE_CONTROL_FIELD, DEADLOCK_MODE, RELEASE_CONTROL_FIELD} = 7'h00;
		{ARBITRATION_REQUEST_FIELD, MODIFIER_SOURCE_REGISTER, lag} = 16'h0000;
		{MASTER_WANT_BUS_N, INTERRUPT_ACK_REQUEST_N, INDIVISIBLE_CYCLE_IN_N} = 3'h7;
		{NARROW_PORT_N, AS_IN_N, RELEASE_REQ_N, SLAVE_SELECT_N, other_req_n} = 5'h1F;
		{SLAVE_DONE, SLAVE_INDIVISIBLE, BLOCK_XFER, grant_en} = 4'h0;
		TRANSFER_SIZE_CODE = `VMC_SIZ_LONG;
		{LOCAL_ADDR_LOW, FUNCTION_CODE_IN} = 4'h0;
		LOCAL_WRITE = 1'b1;
		ADDRESS_SIZE_SELECT = `VMC_AS_A32;
		tick(4);
		RST_N = 1'b1;
		tick(1);
	endtask : rst

	task automatic results();
		if (fails == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_am();
		rst();
		for (int i = 0; i < 16; i++) begin
			ADDRESS_SIZE_SELECT = i[3] ? `VMC_AS_A24 : `VMC_AS_A32;
			FUNCTION_CODE_IN = i[1:0];
			BLOCK_XFER = i[2];
			tick(2);
			`CHK("am std", {i[3] ? 3'h7 : 3'h1, i[2] ? {i[1], 2'h3} : {i[1:0], ~i[0]}}, AM_OUT)
		end
		ADDRESS_SIZE_SELECT = `VMC_AS_USER;
		BLOCK_XFER = 1'b0;
		for (int i = 0; i < 8; i++) begin
			MODIFIER_SOURCE_REGISTER = i[2] ? 8'hA5 : 8'h25;
			FUNCTION_CODE_IN = i[1:0];
			tick(2);
			`CHK("am src", i[2] ? {3'h4, i[1:0], ~i[0]} : 6'h25, AM_OUT)
		end
	endtask : t_am

	task automatic t_fair();
		rst();
		MASTER_WANT_BUS_N = 1'b0;
		`WAITV(BR_N, 1'b0, 8)
		`CHK("br plain", 1'b0, BR_N)
		rst();
		ARBITRATION_REQUEST_FIELD = `VMC_ARB_NOTO;
		other_req_n = 1'b0;
		MASTER_WANT_BUS_N = 1'b0;
		tick(40);
		`CHK("br fair hold", 1'b1, BR_N)
		other_req_n = 1'b1;
		`WAITV(BR_N, 1'b0, 8)
		`CHK("br fair go", 1'b0, BR_N)
		rst();
		// three steps: expiry lands between two and four steps after the request
		ARBITRATION_REQUEST_FIELD = 4'h3;
		other_req_n = 1'b0;
		MASTER_WANT_BUS_N = 1'b0;
		tick(6);
		`CHK("br early", 1'b1, BR_N)
		`WAITV(BR_N, 1'b0, 20)
		`CHK("br timeout", 1'b0, BR_N)
	endtask : t_fair

	task automatic t_rmc();
		logic [15:0] req = 16'h44CC;
		logic [15:0] str = 16'hA0F0;
		for (int i = 0; i < 16; i++) begin
			rst();
			INDIVISIBLE_CONTROL_FIELD = i[3:1];
			TRANSFER_SIZE_CODE = i[0] ? `VMC_SIZ_BYTE : `VMC_SIZ_WORD;
			tick(1);
			INDIVISIBLE_CYCLE_IN_N = 1'b0;
			tick(6);
			`CHK("rmc request", ~req[i], BR_N)
			// stretching only shows on a cycle that owns the bus
			{grant_en, MASTER_WANT_BUS_N} = 2'h2;
			`WAITV(BBSY_N, 1'b0, 20)
			tick(1);
			`CHK("rmc stretch", str[i], AS_STRETCH)
		end
	endtask : t_rmc

	task automatic t_xfer();
		logic [7:0] exp [4] = '{8'h02, 8'h91, 8'h81, 8'h85};
		logic [7:0] seen;
		logic [1:0] siz [4] = '{`VMC_SIZ_LONG, `VMC_SIZ_BYTE, `VMC_SIZ_WORD, `VMC_SIZ_LONG};
		for (int i = 0; i < 4; i++) begin
			rst();
			INDIVISIBLE_CONTROL_FIELD = `VMC_ICR_HOLD_ONLY;
			TRANSFER_SIZE_CODE = siz[i];
			NARROW_PORT_N = (i != 3);
			{grant_en, lag} = 5'h16;
			INDIVISIBLE_CYCLE_IN_N = 1'b0;
			MASTER_WANT_BUS_N = 1'b0;
			for (k = 0; k < 40 && BBSY_N !== 1'b0; k++) begin
				`CHK("ack early", 1'b1, PORT_ACK_UPPER_N)
				tick(1);
			end
			`WAITV(PORT_ACK_UPPER_N, 1'b0, 20)
			seen = {LWORD_N, A01, DS_N, PORT_ACK_UPPER_N, PORT_ACK_LOWER_N,
				SWAP_DATA_ENABLE_N, ISOLATION_BUFFER_ENABLE_N};
			`CHK("xfer", exp[i], seen)
		end
	endtask : t_xfer

	task automatic t_dead();
		for (int j = 0; j < 3; j++) begin
			rst();
			DEADLOCK_MODE = j[1:0];
			RELEASE_CONTROL_FIELD = (j == 0) ? `VMC_REL_ROR : `VMC_REL_RWD;
			INDIVISIBLE_CYCLE_IN_N = (j != 2);
			if (j == 1) begin
				INTERRUPT_ACK_REQUEST_N = 1'b0;
			end else begin
				MASTER_WANT_BUS_N = 1'b0;
			end
			`WAITV(BR_N, 1'b0, 8)
			{SLAVE_SELECT_N, AS_IN_N} = 2'h0;
			`WAITV(DEADLOCK_OUT_N, 1'b0, 6)
			`CHK("deadlock", {1'b0, j == 0, j != 1}, {DEADLOCK_OUT_N, LOCAL_BUS_ERROR_OUT_N, HALT_N})
			{MASTER_WANT_BUS_N, INTERRUPT_ACK_REQUEST_N, INDIVISIBLE_CYCLE_IN_N} = 3'h7;
			tick(10);
			`CHK("deadlock held", 1'b0, DEADLOCK_OUT_N)
			`CHK("still requesting", 1'b0, BR_N)
			SLAVE_DONE = 1'b1;
			tick(1);
			{SLAVE_DONE, SLAVE_SELECT_N, AS_IN_N} = 3'h3;
			`WAITV(DEADLOCK_OUT_N, 1'b1, 6)
			`CHK("deadlock end", 1'b1, DEADLOCK_OUT_N)
			grant_en = 1'b1;
			`WAITV(BBSY_N, 1'b0, 20)
			`CHK("late grant busy", 1'b0, BBSY_N)
			tick(j == 0 ? 30 : 8);
			`CHK("busy minimum", 1'b0, BBSY_N)
			RELEASE_REQ_N = 1'b0;
			`WAITV(BBSY_N, 1'b1, 8)
			`CHK("busy release", 1'b1, BBSY_N)
		end
	endtask : t_dead

	task automatic t_self();
		rst();
		grant_en = 1'b1;
		MASTER_WANT_BUS_N = 1'b0;
		`WAITV(BBSY_N, 1'b0, 20)
		{SLAVE_SELECT_N, AS_IN_N} = 2'h0;
		`WAITV(BERR_N, 1'b0, 8)
		`CHK("self access", 3'h1, {LOCAL_BUS_ERROR_OUT_N, BERR_N, SELF_ACCESS_STATUS})
		// slave to a single-address indivisible cycle keeps the local bus while strobed
		rst();
		SLAVE_INDIVISIBLE = 1'b1;
		{SLAVE_SELECT_N, AS_IN_N} = 2'h0;
		`WAITV(LOCAL_BUS_REQUEST_N, 1'b0, 8)
		SLAVE_DONE = 1'b1;
		tick(1);
		{SLAVE_DONE, SLAVE_SELECT_N} = 2'h1;
		tick(10);
		`CHK("local held", 1'b0, LOCAL_BUS_REQUEST_N)
		AS_IN_N = 1'b1;
		`WAITV(LOCAL_BUS_REQUEST_N, 1'b1, 8)
		`CHK("local freed", 1'b1, LOCAL_BUS_REQUEST_N)
	endtask : t_self

	task automatic t_capture_hold_release();
		rst();
		grant_en = 1'b1;
		RELEASE_CONTROL_FIELD = `VMC_REL_CAPTURE_HOLD_RELEASE;
		`WAITV(BBSY_N, 1'b0, 20)
		tick(20);
		`CHK("capture held", 1'b0, BBSY_N)
		RELEASE_CONTROL_FIELD = `VMC_REL_RWD;
		`WAITV(BBSY_N, 1'b1, 20)
		`CHK("capture freed", 1'b1, BBSY_N)
	endtask : t_capture_hold_release

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst();
		t_am();
		t_fair();
		t_rmc();
		t_xfer();
		t_dead();
		t_self();
		t_capture_hold_release();
		results();
	end

	// the whole run needs about a thousand cycles; this limit is thirty thousand
	initial begin
		#300000;
		fails++;
		results();
	end
endmodule : vme_master_cycle_control_tb_top
